// [design/cca_channel.sv]
// one capture/compare module: capture, match, toggle, frequency output, modulation
// assumes a synchronised pin level and the shared counter on the same clock
`timescale 1ns/1ps
`default_nettype none
module cca_channel (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [15:0] counter,
    input  wire logic [7:0]  mode,
    input  wire logic [1:0]  cycle_len,
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic [7:0]  wdata,
    input  wire logic        pin_sync,
    output logic      [15:0] value,
    output logic             module_pin,
    output logic             event_pulse
);
    typedef struct packed {
        logic [15:0] value;
        logic        prev;
        logic        pin;
        logic        ev;
    } cca_chan_s;

    cca_chan_s   r;
    cca_chan_s   next_r;
    logic        rise;
    logic        fall;
    logic        match;
    logic        cap;
    logic [15:0] msk;

    // ==========================================================
    // channel behaviour
    always_comb begin
        next_r = r;
        next_r.ev = 1'b0;
        next_r.prev = pin_sync;
        rise = pin_sync & ~r.prev;
        fall = ~pin_sync & r.prev;
        cap = (rise & mode[cca_pkg::BIT_RISE]) | (fall & mode[cca_pkg::BIT_FALL]);
        match = mode[cca_pkg::BIT_COMP] & (counter == r.value);
        msk = mode[cca_pkg::BIT_WIDE] ? 16'hFFFF : ~(cca_pkg::CYCLE_BASE << cycle_len);
        if (cap) begin
            next_r.value = counter;
            next_r.ev = 1'b1;
        end else begin
            if (wr_low) begin
                next_r.value[7:0] = wdata;
            end
            if (wr_high) begin
                next_r.value[15:8] = wdata;
            end
        end
        if (match && mode[cca_pkg::BIT_MATCH]) begin
            next_r.ev = 1'b1;
        end
        if (mode[cca_pkg::BIT_COMP]) begin
            if (mode[cca_pkg::BIT_TOGGLE] && mode[cca_pkg::BIT_MOD]) begin
                // frequency output: toggle and step the low byte by the high byte
                if (counter[7:0] == r.value[7:0]) begin
                    next_r.pin = ~r.pin;
                    next_r.value[7:0] = r.value[7:0] + r.value[15:8];
                end
            end else if (mode[cca_pkg::BIT_MOD]) begin
                next_r.pin = (counter & msk) >= (r.value & msk);
            end else if (mode[cca_pkg::BIT_TOGGLE] && match) begin
                next_r.pin = ~r.pin;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign value       = r.value;
    assign module_pin  = r.pin;
    assign event_pulse = r.ev;

    // ==========================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_rise_capture: assert property (rise && mode[cca_pkg::BIT_RISE] |=>
        value == $past(counter) && event_pulse)
        else $error("rising edge not captured");
    a_toggle_pin: assert property (match && mode[cca_pkg::BIT_TOGGLE]
        && !mode[cca_pkg::BIT_MOD] |=> module_pin != $past(module_pin))
        else $error("pin did not toggle on match");
    a_no_capture: assert property (!mode[cca_pkg::BIT_RISE] && !mode[cca_pkg::BIT_FALL]
        && !mode[cca_pkg::BIT_COMP] && !wr_low && !wr_high |=> $stable(value))
        else $error("value changed without cause");
    c_capture: cover property (cap);
endmodule
`default_nettype wire

// [design/cca_core.sv]
// counter array core: shared counter, three modules, registers over AXI4-Lite
// assumes one AXI4-Lite master on aclk; pins are asynchronous and are synchronised here
//
// Contract
// - mode bit 7 picks 8..11-bit or full 16-bit modulation cycle
// - comparator works only while mode bit 6 is one
// - rising input edges capture only when mode bit 5 is one
// - falling edges capture when bit 4 is one; both bits capture either edge
// - with bit 3 set, counter equal to compare value sets the flag
// - with bit 2 set, counter equal to compare value inverts the pin
// - toggle plus modulation enables together give frequency output
// - bit 1 drives modulated waveform, width chosen by bit 7
// - flag raises interrupt only when mode bit 0 is one
// - three mode registers at 0xDA, 0xDB, 0xDC, read/write, reset zero
// - watchdog enabled: writes to module 2 mode register are ignored
// - watchdog enabled: writes to counter low byte 0xF9 are blocked
// - watchdog enabled: writes to counter high byte 0xFA are blocked
// - high byte reads a snapshot loaded when the low byte is read
// - counter is 16 bits, low byte exposed, both bytes reset zero
// - outside 16-bit mode, shared two-bit field sets 8..11-bit cycle
// - writing a compare low byte clears that module's comparator enable
// - writing a compare high byte sets that module's comparator enable
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module cca_core (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [11:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic      [1:0]  bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [11:0] araddr,
    input  wire logic [2:0]  arprot,
    output logic             rvalid,
    input  wire logic        rready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    input  wire logic [2:0]  module_pin_in,
    output logic      [2:0]  module_pin,
    output logic             irq
);
    typedef struct packed {
        logic                 aw_rdy;
        logic                 w_rdy;
        logic                 ar_rdy;
        logic                 aw_got;
        logic                 w_got;
        logic [11:0]          waddr;
        logic [7:0]           wdat;
        logic                 wen;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [1:0]           rresp;
        logic [7:0]           rdata;
        logic [2:0][7:0]      mode;
        logic [15:0]          counter;
        logic [7:0]           snap;
        logic [1:0]           cyc;
        logic                 run;
        logic                 wdog;
        logic [2:0]           flags;
        logic [2:0]           mask;
        logic                 irq;
        logic [2:0]           s1;
        logic [2:0]           s2;
    } cca_core_s;

    cca_core_s   r;
    cca_core_s   next_r;
    logic [2:0]  wr_low;
    logic [2:0]  wr_high;
    logic [2:0]  ch_event;
    logic [2:0]  ch_pin;
    logic [15:0] ch_val [3];
    logic [2:0]  ecc;
    logic [7:0]  widx;
    logic [7:0]  ridx;
    logic        wok;
    logic        rok;
    logic        fire;

    function automatic logic known(input logic [7:0] i);
        case (i)
            cca_pkg::IDX_MASK, cca_pkg::IDX_STATUS, cca_pkg::IDX_ARRAY,
            cca_pkg::IDX_MODE0, cca_pkg::IDX_MODE1, cca_pkg::IDX_MODE2,
            cca_pkg::IDX_CYCLE, cca_pkg::IDX_CNT_LOW, cca_pkg::IDX_CNT_HIGH,
            cca_pkg::IDX_CMPL0, cca_pkg::IDX_CMPH0, cca_pkg::IDX_CMPL1,
            cca_pkg::IDX_CMPH1, cca_pkg::IDX_CMPL2, cca_pkg::IDX_CMPH2: known = 1'b1;
            default: known = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // address decode
    assign widx = r.waddr[9:2];
    assign ridx = araddr[9:2];
    assign wok  = (r.waddr[11:10] == 2'h0) && (r.waddr[1:0] == 2'h0) && known(widx);
    assign rok  = (araddr[11:10] == 2'h0) && (araddr[1:0] == 2'h0) && known(ridx);
    assign fire = r.aw_got && r.w_got && !r.bvalid;

    // ==========================================================
    // modules
    genvar g;
    generate
        for (g = 0; g < cca_pkg::NUM_MODULES; g++) begin : gen_ch
            cca_channel u_ch (
                .aclk        (aclk),
                .aresetn     (aresetn),
                .counter     (r.counter),
                .mode        (r.mode[g]),
                .cycle_len   (r.cyc),
                .wr_low      (wr_low[g]),
                .wr_high     (wr_high[g]),
                .wdata       (r.wdat),
                .pin_sync    (r.s2[g]),
                .value       (ch_val[g]),
                .module_pin  (ch_pin[g]),
                .event_pulse (ch_event[g])
            );
        end
    endgenerate

    // ==========================================================
    // next state
    always_comb begin
        next_r = r;
        wr_low = 3'h0;
        wr_high = 3'h0;
        ecc = 3'h0;
        next_r.s1 = module_pin_in;
        next_r.s2 = r.s1;
        if (r.run) begin
            next_r.counter = r.counter + 16'h0001;
        end
        // write channel
        if (awvalid && r.aw_rdy) begin
            next_r.aw_got = 1'b1;
            next_r.waddr = awaddr;
        end
        if (wvalid && r.w_rdy) begin
            next_r.w_got = 1'b1;
            next_r.wdat = wdata[7:0];
            next_r.wen = wstrb[0];
        end
        if (r.bvalid && bready) begin
            next_r.bvalid = 1'b0;
        end
        if (fire) begin
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = wok ? cca_pkg::RESP_OKAY : cca_pkg::RESP_SLVERR;
            if (wok && r.wen) begin
                case (widx)
                    cca_pkg::IDX_MODE0: next_r.mode[0] = r.wdat;
                    cca_pkg::IDX_MODE1: next_r.mode[1] = r.wdat;
                    cca_pkg::IDX_MODE2: begin
                        if (!r.wdog) begin
                            next_r.mode[2] = r.wdat;
                        end
                    end
                    cca_pkg::IDX_CNT_LOW: begin
                        if (!r.wdog) begin
                            next_r.counter[7:0] = r.wdat;
                        end
                    end
                    cca_pkg::IDX_CNT_HIGH: begin
                        if (!r.wdog) begin
                            next_r.counter[15:8] = r.wdat;
                        end
                    end
                    cca_pkg::IDX_CYCLE: next_r.cyc = r.wdat[1:0];
                    cca_pkg::IDX_ARRAY: begin
                        next_r.run = r.wdat[cca_pkg::BIT_RUN];
                        next_r.wdog = r.wdat[cca_pkg::BIT_WDOG];
                    end
                    cca_pkg::IDX_STATUS: next_r.flags = r.flags & ~r.wdat[2:0];
                    cca_pkg::IDX_MASK: next_r.mask = r.wdat[2:0];
                    cca_pkg::IDX_CMPL0: wr_low[0] = 1'b1;
                    cca_pkg::IDX_CMPL1: wr_low[1] = 1'b1;
                    cca_pkg::IDX_CMPL2: wr_low[2] = 1'b1;
                    cca_pkg::IDX_CMPH0: wr_high[0] = 1'b1;
                    cca_pkg::IDX_CMPH1: wr_high[1] = 1'b1;
                    cca_pkg::IDX_CMPH2: wr_high[2] = 1'b1;
                    default: next_r.bresp = cca_pkg::RESP_SLVERR;
                endcase
            end
        end
        for (int i = 0; i < cca_pkg::NUM_MODULES; i++) begin
            if (!(i == 2 && r.wdog)) begin
                if (wr_low[i]) begin
                    next_r.mode[i][cca_pkg::BIT_COMP] = 1'b0;
                end
                if (wr_high[i]) begin
                    next_r.mode[i][cca_pkg::BIT_COMP] = 1'b1;
                end
            end
        end
        // flag set wins over a same-cycle clear
        next_r.flags = next_r.flags | ch_event;
        for (int i = 0; i < cca_pkg::NUM_MODULES; i++) begin
            ecc[i] = next_r.mode[i][cca_pkg::BIT_IRQ];
        end
        next_r.irq = |(next_r.flags & next_r.mask & ecc);
        // read channel
        if (r.rvalid && rready) begin
            next_r.rvalid = 1'b0;
        end
        if (arvalid && r.ar_rdy) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = rok ? cca_pkg::RESP_OKAY : cca_pkg::RESP_SLVERR;
            next_r.rdata = 8'h00;
            if (rok) begin
                case (ridx)
                    cca_pkg::IDX_MODE0: next_r.rdata = r.mode[0];
                    cca_pkg::IDX_MODE1: next_r.rdata = r.mode[1];
                    cca_pkg::IDX_MODE2: next_r.rdata = r.mode[2];
                    cca_pkg::IDX_CNT_LOW: begin
                        next_r.rdata = r.counter[7:0];
                        next_r.snap = r.counter[15:8];
                    end
                    cca_pkg::IDX_CNT_HIGH: next_r.rdata = r.snap;
                    cca_pkg::IDX_CYCLE: next_r.rdata = {6'h00, r.cyc};
                    cca_pkg::IDX_ARRAY: begin
                        next_r.rdata[cca_pkg::BIT_RUN] = r.run;
                        next_r.rdata[cca_pkg::BIT_WDOG] = r.wdog;
                    end
                    cca_pkg::IDX_STATUS: next_r.rdata = {5'h00, r.flags};
                    cca_pkg::IDX_MASK: next_r.rdata = {5'h00, r.mask};
                    cca_pkg::IDX_CMPL0: next_r.rdata = ch_val[0][7:0];
                    cca_pkg::IDX_CMPL1: next_r.rdata = ch_val[1][7:0];
                    cca_pkg::IDX_CMPL2: next_r.rdata = ch_val[2][7:0];
                    cca_pkg::IDX_CMPH0: next_r.rdata = ch_val[0][15:8];
                    cca_pkg::IDX_CMPH1: next_r.rdata = ch_val[1][15:8];
                    cca_pkg::IDX_CMPH2: next_r.rdata = ch_val[2][15:8];
                    default: next_r.rdata = 8'h00;
                endcase
            end
        end
        next_r.aw_rdy = !next_r.aw_got && !next_r.bvalid;
        next_r.w_rdy = !next_r.w_got && !next_r.bvalid;
        next_r.ar_rdy = !next_r.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // outputs
    assign awready    = r.aw_rdy;
    assign wready     = r.w_rdy;
    assign bvalid     = r.bvalid;
    assign bresp      = r.bresp;
    assign arready    = r.ar_rdy;
    assign rvalid     = r.rvalid;
    assign rdata      = {24'h000000, r.rdata};
    assign rresp      = r.rresp;
    assign module_pin = ch_pin;
    assign irq        = r.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic wr_now;
    assign wr_now = fire && wok && r.wen;

    a_mode_write: assert property (wr_now && widx == cca_pkg::IDX_MODE1 |=>
        r.mode[1] == $past(r.wdat))
        else $error("mode register write lost");
    a_wdog_mode_lock: assert property (wr_now && widx == cca_pkg::IDX_MODE2 && r.wdog
        |=> $stable(r.mode[2]))
        else $error("module 2 mode changed under watchdog");
    a_low_lock: assert property (wr_now && widx == cca_pkg::IDX_CNT_LOW && r.wdog
        && !r.run |=> $stable(r.counter))
        else $error("counter low byte written under watchdog");
    a_high_lock: assert property (wr_now && widx == cca_pkg::IDX_CNT_HIGH && r.wdog
        && !r.run |=> $stable(r.counter))
        else $error("counter high byte written under watchdog");
    a_low_write: assert property (wr_now && widx == cca_pkg::IDX_CNT_LOW && !r.wdog
        |=> r.counter[7:0] == $past(r.wdat))
        else $error("counter low byte write lost");
    a_snap_read: assert property (arvalid && arready && rok && ridx == cca_pkg::IDX_CNT_LOW
        ##1 (!arready)[*1] ##1 arvalid && arready && rok && ridx == cca_pkg::IDX_CNT_HIGH
        |=> rdata[7:0] == $past(r.counter[15:8], 3))
        else $error("high byte does not read the snapshot");
    a_cmp_low_clr: assert property (wr_now && widx == cca_pkg::IDX_CMPL0
        |=> !r.mode[0][cca_pkg::BIT_COMP])
        else $error("compare low write kept comparator on");
    a_cmp_high_set: assert property (wr_now && widx == cca_pkg::IDX_CMPH1
        |=> r.mode[1][cca_pkg::BIT_COMP])
        else $error("compare high write left comparator off");
    a_flag_set: assert property (ch_event[0] |=> r.flags[0] ##1 1'b1)
        else $error("module event did not set flag");
    a_irq_mask: assert property (!r.mode[0][cca_pkg::BIT_IRQ] && !r.mode[1][cca_pkg::BIT_IRQ]
        && !r.mode[2][cca_pkg::BIT_IRQ] |-> !irq)
        else $error("interrupt raised while masked");
    a_resp_order: assert property (fire |=> bvalid && $past(r.aw_got) && !awready)
        else $error("write response not after both channels");

    a_high_write: assert property (wr_now && widx == cca_pkg::IDX_CNT_HIGH
        && !r.wdog && !r.run |=> r.counter[15:8] == $past(r.wdat))
        else $error("counter high byte write lost");
    a_wdog_cmp_hold: assert property (wr_now && widx == cca_pkg::IDX_CMPH2
        && r.wdog |=> $stable(r.mode[2]))
        else $error("module 2 comparator changed under watchdog");
    a_irq_raise: assert property ((r.flags[0] && r.mask[0]
        && r.mode[0][cca_pkg::BIT_IRQ]) |-> irq)
        else $error("unmasked flag raised no interrupt");
    a_flag_clear: assert property (wr_now && widx == cca_pkg::IDX_STATUS && r.wdat[0]
        && !ch_event[0] |=> !r.flags[0])
        else $error("status flag not cleared by write of one");
    a_read_slverr: assert property (arvalid && arready && !rok
        |=> rresp == cca_pkg::RESP_SLVERR && rdata == 32'h00000000)
        else $error("unmapped read not refused");
    a_freq_step: assert property (r.mode[0][cca_pkg::BIT_TOGGLE]
        && r.mode[0][cca_pkg::BIT_MOD] && r.mode[0][cca_pkg::BIT_COMP]
        && r.counter[7:0] == ch_val[0][7:0] |=> module_pin[0] != $past(module_pin[0]))
        else $error("frequency output did not toggle");

    c_irq: cover property (irq);
    c_freq: cover property (r.mode[0][cca_pkg::BIT_TOGGLE] && r.mode[0][cca_pkg::BIT_MOD]
        && r.counter[7:0] == ch_val[0][7:0]);
    c_slverr: cover property (bvalid && bresp == cca_pkg::RESP_SLVERR);
    c_snap: cover property (rvalid && ridx == cca_pkg::IDX_CNT_HIGH);
endmodule
`default_nettype wire

// [design/cca_pkg.sv]
// constants for the counter array capture/compare block
// assumes a 32-bit AXI4-Lite master; register index n sits at byte address 4*n
package cca_pkg;
    localparam int         NUM_MODULES  = 3;
    localparam int         ADDR_W       = 12;
    // register indices
    localparam logic [7:0] IDX_MASK     = 8'hD7;
    localparam logic [7:0] IDX_STATUS   = 8'hD8;
    localparam logic [7:0] IDX_ARRAY    = 8'hD9;
    localparam logic [7:0] IDX_MODE0    = 8'hDA;
    localparam logic [7:0] IDX_MODE1    = 8'hDB;
    localparam logic [7:0] IDX_MODE2    = 8'hDC;
    localparam logic [7:0] IDX_CYCLE    = 8'hF7;
    localparam logic [7:0] IDX_CNT_LOW  = 8'hF9;
    localparam logic [7:0] IDX_CNT_HIGH = 8'hFA;
    localparam logic [7:0] IDX_CMPL0    = 8'hFB;
    localparam logic [7:0] IDX_CMPH0    = 8'hFC;
    localparam logic [7:0] IDX_CMPL1    = 8'hE9;
    localparam logic [7:0] IDX_CMPH1    = 8'hEA;
    localparam logic [7:0] IDX_CMPL2    = 8'hEB;
    localparam logic [7:0] IDX_CMPH2    = 8'hEC;
    // module mode fields
    localparam int         BIT_WIDE     = 7;
    localparam int         BIT_COMP     = 6;
    localparam int         BIT_RISE     = 5;
    localparam int         BIT_FALL     = 4;
    localparam int         BIT_MATCH    = 3;
    localparam int         BIT_TOGGLE   = 2;
    localparam int         BIT_MOD      = 1;
    localparam int         BIT_IRQ      = 0;
    // array mode fields
    localparam int         BIT_RUN      = 0;
    localparam int         BIT_WDOG     = 6;
    localparam logic [7:0] MODE_RESET   = 8'h00;
    localparam logic [15:0] CYCLE_BASE  = 16'hFF00;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage

// [dv/cca_pins.sv]
// external pin model: capture inputs at the bench's requested level, outputs watched
// assumes lvl changes only just after a rising edge of aclk
`timescale 1ns/1ps
`default_nettype none
module cca_pins (
    input  wire logic       aclk,
    input  wire logic [2:0] lvl,
    input  wire logic [2:0] module_pin,
    output logic      [2:0] module_pin_in,
    output logic      [2:0] seen
);
    // ========
    // pins
    assign module_pin_in = lvl;
    always_ff @(posedge aclk) begin
        seen <= module_pin;
    end
endmodule
`default_nettype wire

// [dv/test_counter_array_capture_compare_mode.sv]
// bench for cca_core: register sequences over AXI4-Lite plus pin stimulus
// assumes bready and rready held high; register index n sits at byte 4*n
`timescale 1ns/1ps
`default_nettype none
module test_counter_array_capture_compare_mode;
    logic             aclk = 1'h0;
    logic             aresetn = 1'h0;
    logic             awvalid = 1'h0;
    logic             wvalid = 1'h0;
    logic             arvalid = 1'h0;
    logic      [11:0] awaddr = 12'h0;
    logic      [11:0] araddr = 12'h0;
    logic      [31:0] wdata = 32'h0;
    logic      [2:0]  lvl = 3'h0;
    wire logic        awready, wready, bvalid, arready, rvalid, irq;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [2:0]  pin_in, pin_out, seen;
    int               n_errors = 0;
    int               samples_checked = 0;
    logic      [7:0]  r;
    logic      [1:0]  rs;
    logic      [1:0]  bs;
    logic             b;
    logic      [7:0]  idx [5] = '{8'hDA, 8'hDB, 8'hDC, 8'hF9, 8'hFA};
    logic      [7:0]  pat [5] = '{8'hA5, 8'h5A, 8'hC3, 8'h34, 8'h12};
    logic      [7:0]  cm [6] = '{8'h20, 8'h20, 8'h10, 8'h10, 8'h30, 8'h30};
    logic             cl [6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
    logic      [7:0]  cf [6] = '{8'h04, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04};

    always #4 aclk = ~aclk;

    cca_core u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'h1), .bvalid(bvalid), .bready(1'h1), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(1'h1),
        .rdata(rdata), .rresp(rresp), .module_pin_in(pin_in), .module_pin(pin_out),
        .irq(irq));
    cca_pins u_pins (.aclk(aclk), .lvl(lvl), .module_pin(pin_out), .module_pin_in(pin_in),
        .seen(seen));

    // ========
    // tasks
    task automatic give_verdict;
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fail;
        n_errors++;
        $display("[ERR] %0t bus timeout", $time);
        give_verdict();
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        int k;
        awaddr <= {2'h0, i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        if (k == 40) fail();
        bs = bresp;
    endtask
    task automatic rd(input logic [7:0] i);
        int k;
        araddr <= {2'h0, i, 2'h0};
        arvalid <= 1'h1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        if (k == 40) fail();
        r = rdata[7:0];
        rs = rresp;
    endtask
    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        rd(i);
        chk(r, e);
    endtask

    // ========
    // sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        foreach (idx[j]) rc(idx[j], 8'h00);
        foreach (idx[j]) wr(idx[j], pat[j]);
        foreach (idx[j]) rc(idx[j], pat[j]);
        wr(8'hFA, 8'h56);
        rc(8'hFA, 8'h12);
        rc(8'hF9, 8'h34);
        rc(8'hFA, 8'h56);
        rd(8'h00);
        chk({6'h0, rs}, {6'h0, cca_pkg::RESP_SLVERR});
        wr(8'h00, 8'h00);
        chk({6'h0, bs}, {6'h0, cca_pkg::RESP_SLVERR});
        wr(8'hDA, 8'h40);
        wr(8'hFB, 8'h10);
        rc(8'hDA, 8'h00);
        wr(8'hFC, 8'h00);
        rc(8'hDA, 8'h40);
        // match with interrupt on module 0, module 1 comparator off
        wr(8'hE9, 8'h10);
        wr(8'hEA, 8'h00);
        wr(8'hDB, 8'h09);
        wr(8'hDA, 8'h49);
        wr(8'hDC, 8'h00);
        wr(8'hD7, 8'h03);
        wr(8'hF9, 8'h00);
        wr(8'hFA, 8'h00);
        wr(8'hD8, 8'h07);
        wr(8'hD9, 8'h01);
        repeat (30) @(posedge aclk);
        wr(8'hD9, 8'h00);
        rc(8'hD8, 8'h01);
        chk({7'h0, irq}, 8'h01);
        wr(8'hDA, 8'h48);
        repeat (2) @(posedge aclk);
        chk({7'h0, irq}, 8'h00);
        wr(8'hD8, 8'h01);
        rc(8'hD8, 8'h00);
        // toggle on one pass of the match value
        wr(8'hDA, 8'h44);
        wr(8'hF9, 8'h0E);
        repeat (3) @(posedge aclk);
        b = seen[0];
        wr(8'hD9, 8'h01);
        repeat (8) @(posedge aclk);
        wr(8'hD9, 8'h00);
        chk({7'h0, seen[0]}, {7'h0, ~b});
        // capture edges on module 2
        wr(8'hF9, 8'h34);
        wr(8'hFA, 8'h12);
        for (int j = 0; j < 6; j++) begin
            wr(8'hD8, 8'h07);
            wr(8'hDC, cm[j]);
            lvl[2] <= cl[j];
            repeat (8) @(posedge aclk);
            rc(8'hD8, cf[j]);
        end
        rc(8'hEB, 8'h34);
        rc(8'hEC, 8'h12);
        // watchdog lock
        wr(8'hD9, 8'h40);
        wr(8'hDC, 8'hFF);
        chk({6'h0, bs}, {6'h0, cca_pkg::RESP_OKAY});
        wr(8'hEC, 8'h12);
        wr(8'hF9, 8'h77);
        wr(8'hFA, 8'h77);
        rc(8'hDC, 8'h30);
        rc(8'hF9, 8'h34);
        rc(8'hFA, 8'h12);
        wr(8'hD9, 8'h00);
        wr(8'hDC, 8'h5A);
        rc(8'hDC, 8'h5A);
        // modulation widths
        wr(8'hFB, 8'h00);
        wr(8'hFC, 8'h80);
        wr(8'hDA, 8'hC2);
        wr(8'hF9, 8'h00);
        wr(8'hFA, 8'h70);
        repeat (4) @(posedge aclk);
        chk({7'h0, seen[0]}, 8'h00);
        wr(8'hDA, 8'h42);
        repeat (4) @(posedge aclk);
        chk({7'h0, seen[0]}, 8'h01);
        wr(8'hFB, 8'h80);
        wr(8'hFC, 8'h00);
        wr(8'hFA, 8'h01);
        repeat (4) @(posedge aclk);
        chk({7'h0, seen[0]}, 8'h00);
        wr(8'hF7, 8'h01);
        repeat (4) @(posedge aclk);
        chk({7'h0, seen[0]}, 8'h01);
        // frequency output: one low-byte match toggles the pin and steps the value
        wr(8'hDA, 8'h46);
        wr(8'hFC, 8'h10);
        b = seen[0];
        wr(8'hF9, 8'h80);
        repeat (3) @(posedge aclk);
        chk({7'h0, seen[0]}, {7'h0, ~b});
        rc(8'hFB, 8'h90);
        give_verdict();
    end
endmodule
`default_nettype wire
